// file: rtl/pcd_defs.svh
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH

// Register offsets in the switch register space.
`define PCD_P1_SPECIAL_OFS 8'h1a
`define PCD_P2_SPECIAL_OFS 8'h2a
`define PCD_P3_SPECIAL_RSVD_OFS 8'h3a
`define PCD_P1_RESULT_OFS 8'h1b
`define PCD_P2_RESULT_OFS 8'h2b
`define PCD_P3_RESULT_RSVD_OFS 8'h3b

// Field positions of the special control and status byte.
`define PCD_BIT_NEAR_SHORT 7
`define PCD_BIT_RESULT_HI 6
`define PCD_BIT_RESULT_LO 5
`define PCD_BIT_TEST_EN 4
`define PCD_BIT_FORCE_LINK 3
`define PCD_BIT_PWR_SAVE_DIS 2
`define PCD_BIT_REMOTE_LOOP 1
`define PCD_BIT_COUNT_MSB 0

// Reset values of the writable control bits.
`define PCD_RST_TEST_EN 1'b0
`define PCD_RST_FORCE_LINK 1'b0
`define PCD_RST_PWR_SAVE_DIS 1'b1
`define PCD_RST_REMOTE_LOOP 1'b0

// Diagnosis result codes.
`define PCD_RES_NORMAL 2'h0
`define PCD_RES_OPEN 2'h1
`define PCD_RES_SHORT 2'h2
`define PCD_RES_FAILED 2'h3

// Timing: a test that never reports back is declared failed.
`define PCD_CLK_MHZ 20
`define PCD_DIAG_TIMEOUT_US 100000
`define PCD_DIAG_TIMEOUT_CYC (`PCD_DIAG_TIMEOUT_US * `PCD_CLK_MHZ)

`endif

// file: rtl/pcd_diag_seq.sv
`timescale 1ns/1ps
`include "pcd_defs.svh"

module pcd_diag_seq #(
  parameter int unsigned TIMEOUT_CYCLES = `PCD_DIAG_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic test_en_i,
  input wire logic done_i,
  input wire logic [1:0] result_i,
  input wire logic near_short_i,
  input wire logic [8:0] count_i,
  output logic start_o,
  output logic finish_o,
  output logic busy_o,
  output logic [1:0] result_o,
  output logic near_short_o,
  output logic [8:0] count_o
);

  pcd_pkg::pcd_seq_state_t state_reg;
  pcd_pkg::pcd_seq_state_t state_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  pcd_pkg::pcd_diag_code_t result_reg;
  pcd_pkg::pcd_diag_code_t result_next;
  logic short_reg;
  logic short_next;
  pcd_pkg::pcd_fault_count_t count_reg;
  pcd_pkg::pcd_fault_count_t count_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: results change only on the edge that ends a test, so a read
  // during a run always returns the previous test's outcome.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    result_next = result_reg;
    short_next = short_reg;
    count_next = count_reg;
    start_o = 1'b0;
    finish_o = 1'b0;
    case (state_reg)
      pcd_pkg::PCD_SEQ_IDLE: begin
        if (test_en_i) begin
          start_o = 1'b1;
          cnt_next = 32'h0000_0000;
          state_next = pcd_pkg::PCD_SEQ_RUN;
        end
      end
      pcd_pkg::PCD_SEQ_RUN: begin
        if (done_i) begin
          result_next = result_i;
          short_next = near_short_i;
          count_next = count_i;
          finish_o = 1'b1;
          state_next = pcd_pkg::PCD_SEQ_IDLE;
        end else if (cnt_reg == TIMEOUT_CYCLES - 32'h0000_0001) begin
          // The analog side never answered, so the test itself failed.
          result_next = `PCD_RES_FAILED;
          short_next = 1'b0;
          count_next = 9'h000;
          finish_o = 1'b1;
          state_next = pcd_pkg::PCD_SEQ_IDLE;
        end else begin
          cnt_next = cnt_reg + 32'h0000_0001;
        end
      end
      default: begin
        state_next = pcd_pkg::PCD_SEQ_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= pcd_pkg::PCD_SEQ_IDLE;
      cnt_reg <= 32'h0000_0000;
      result_reg <= `PCD_RES_NORMAL;
      short_reg <= 1'b0;
      count_reg <= 9'h000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      result_reg <= result_next;
      short_reg <= short_next;
      count_reg <= count_next;
    end
  end

  // Held results go out straight from flip-flops.
  assign busy_o = (state_reg == pcd_pkg::PCD_SEQ_RUN);
  assign result_o = result_reg;
  assign near_short_o = short_reg;
  assign count_o = count_reg;

endmodule

// file: rtl/pcd_pkg.sv
package pcd_pkg;

  // Sequencer states for one port's cable diagnostic.
  typedef enum {
    PCD_SEQ_IDLE,
    PCD_SEQ_RUN
  } pcd_seq_state_t;

  // Targets of a switch register access.
  typedef enum {
    PCD_TGT_NONE,
    PCD_TGT_P1_SPEC,
    PCD_TGT_P2_SPEC,
    PCD_TGT_P1_RES,
    PCD_TGT_P2_RES,
    PCD_TGT_RSVD
  } pcd_target_t;

  typedef logic [1:0] pcd_diag_code_t;
  typedef logic [8:0] pcd_fault_count_t;

endpackage

// file: rtl/pcd_special_ctrl.sv
`timescale 1ns/1ps
`include "pcd_defs.svh"

module pcd_special_ctrl #(
  parameter int unsigned DIAG_TIMEOUT_CYCLES = `PCD_DIAG_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  // Switch register space access.
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Management PHY register access to the same per-port contents.
  input wire logic mgmt_port_i,
  input wire logic mgmt_sel_result_i,
  input wire logic [7:0] mgmt_wdata_i,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  output logic [7:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  // Analog cable test circuitry, one lane per port.
  output logic [1:0] diag_start_o,
  output logic [1:0] diag_busy_o,
  input wire logic [1:0] diag_done_i,
  input wire logic [3:0] diag_result_i,
  input wire logic [1:0] diag_near_short_i,
  input wire logic [17:0] diag_count_i,
  // Port controls toward the PHYs.
  output logic [1:0] force_link_o,
  output logic [1:0] power_save_en_o,
  output logic [1:0] remote_loop_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding, shared by the read and write paths.
  function automatic pcd_pkg::pcd_target_t decode_addr(input logic [7:0] addr);
    pcd_pkg::pcd_target_t tgt;
    tgt = pcd_pkg::PCD_TGT_NONE;
    if (addr == `PCD_P1_SPECIAL_OFS) begin
      tgt = pcd_pkg::PCD_TGT_P1_SPEC;
    end else if (addr == `PCD_P2_SPECIAL_OFS) begin
      tgt = pcd_pkg::PCD_TGT_P2_SPEC;
    end else if (addr == `PCD_P1_RESULT_OFS) begin
      tgt = pcd_pkg::PCD_TGT_P1_RES;
    end else if (addr == `PCD_P2_RESULT_OFS) begin
      tgt = pcd_pkg::PCD_TGT_P2_RES;
    end else if (addr == `PCD_P3_SPECIAL_RSVD_OFS || addr == `PCD_P3_RESULT_RSVD_OFS) begin
      tgt = pcd_pkg::PCD_TGT_RSVD;
    end
    return tgt;
  endfunction

  pcd_pkg::pcd_target_t bus_tgt;
  logic [7:0] spec_byte [2];
  logic [7:0] res_byte [2];
  logic [1:0] seq_busy;

  assign bus_tgt = decode_addr(reg_addr_i);

  ////////////////////////////////////////////////////////////////////////////
  // One identical slice per port: control bits plus a diagnostic sequencer.
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam pcd_pkg::pcd_target_t SPEC_TGT =
      (p == 0) ? pcd_pkg::PCD_TGT_P1_SPEC : pcd_pkg::PCD_TGT_P2_SPEC;

    logic en_reg;
    logic en_next;
    logic force_reg;
    logic force_next;
    logic pwr_dis_reg;
    logic pwr_dis_next;
    logic loop_reg;
    logic loop_next;
    logic bus_wr;
    logic mgmt_wr;
    logic wr_any;
    logic [7:0] wr_byte;
    logic seq_start;
    logic seq_finish;
    pcd_pkg::pcd_diag_code_t seq_result;
    logic seq_short;
    pcd_pkg::pcd_fault_count_t seq_count;
    logic [7:0] spec_b;
    logic [7:0] res_b;

    // Write steering. The switch bus wins when both paths write one port in
    // the same cycle; the management write is then dropped, not merged.
    always_comb begin
      bus_wr = reg_wr_i && (bus_tgt == SPEC_TGT);
      mgmt_wr = mgmt_wr_i && !mgmt_sel_result_i && (mgmt_port_i == 1'(p));
      wr_any = bus_wr || mgmt_wr;
      wr_byte = bus_wr ? reg_wdata_i : mgmt_wdata_i;
    end

    // Control bit next values. A start written in the very cycle the engine
    // finishes survives the self-clear, and the engine then runs again.
    always_comb begin
      en_next = en_reg;
      force_next = force_reg;
      pwr_dis_next = pwr_dis_reg;
      loop_next = loop_reg;
      if (seq_finish) begin
        en_next = 1'b0;
      end
      if (wr_any) begin
        if (wr_byte[`PCD_BIT_TEST_EN]) begin
          en_next = 1'b1;
        end
        force_next = wr_byte[`PCD_BIT_FORCE_LINK];
        pwr_dis_next = wr_byte[`PCD_BIT_PWR_SAVE_DIS];
        loop_next = wr_byte[`PCD_BIT_REMOTE_LOOP];
      end
    end

    // Control bit registers.
    always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
        en_reg <= `PCD_RST_TEST_EN;
        force_reg <= `PCD_RST_FORCE_LINK;
        pwr_dis_reg <= `PCD_RST_PWR_SAVE_DIS;
        loop_reg <= `PCD_RST_REMOTE_LOOP;
      end else begin
        en_reg <= en_next;
        force_reg <= force_next;
        pwr_dis_reg <= pwr_dis_next;
        loop_reg <= loop_next;
      end
    end

    // Engine for this port; it holds the last results itself.
    pcd_diag_seq #(
      .TIMEOUT_CYCLES(DIAG_TIMEOUT_CYCLES)
    ) u_seq (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .test_en_i(en_reg),
      .done_i(diag_done_i[p]),
      .result_i(diag_result_i[2*p+1:2*p]),
      .near_short_i(diag_near_short_i[p]),
      .count_i(diag_count_i[9*p+8:9*p]),
      .start_o(seq_start),
      .finish_o(seq_finish),
      .busy_o(seq_busy[p]),
      .result_o(seq_result),
      .near_short_o(seq_short),
      .count_o(seq_count)
    );

    // Readback bytes built from live registers only.
    always_comb begin
      spec_b = 8'h00;
      spec_b[`PCD_BIT_NEAR_SHORT] = seq_short;
      spec_b[`PCD_BIT_RESULT_HI:`PCD_BIT_RESULT_LO] = seq_result;
      spec_b[`PCD_BIT_TEST_EN] = en_reg;
      spec_b[`PCD_BIT_FORCE_LINK] = force_reg;
      spec_b[`PCD_BIT_PWR_SAVE_DIS] = pwr_dis_reg;
      spec_b[`PCD_BIT_REMOTE_LOOP] = loop_reg;
      spec_b[`PCD_BIT_COUNT_MSB] = seq_count[8];
      res_b = seq_count[7:0];
    end

    // Each slice drives only its own array element, and only by continuous
    // assignment, so no two processes ever write the shared readback arrays.
    assign spec_byte[p] = spec_b;
    assign res_byte[p] = res_b;

    // Port controls. Power saving is active when its disable bit is clear.
    assign diag_start_o[p] = seq_start;
    assign force_link_o[p] = force_reg;
    assign power_save_en_o[p] = !pwr_dis_reg;
    assign remote_loop_o[p] = loop_reg;
  end

  assign diag_busy_o = seq_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Switch bus read path. Data is registered one cycle after the strobe;
  // unmapped and reserved addresses answer zero so software never sees junk.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd_i;
    if (reg_rd_i) begin
      if (bus_tgt == pcd_pkg::PCD_TGT_P1_SPEC) begin
        rdata_next = spec_byte[0];
      end else if (bus_tgt == pcd_pkg::PCD_TGT_P2_SPEC) begin
        rdata_next = spec_byte[1];
      end else if (bus_tgt == pcd_pkg::PCD_TGT_P1_RES) begin
        rdata_next = res_byte[0];
      end else if (bus_tgt == pcd_pkg::PCD_TGT_P2_RES) begin
        rdata_next = res_byte[1];
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // Switch bus read registers.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Management read path. It reads the very same bytes as the switch bus,
  // which keeps the two views consistent without any copy to maintain.
  logic [7:0] mrdata_reg;
  logic [7:0] mrdata_next;
  logic mrvalid_reg;
  logic mrvalid_next;

  always_comb begin
    mrdata_next = mrdata_reg;
    mrvalid_next = mgmt_rd_i;
    if (mgmt_rd_i) begin
      if (mgmt_sel_result_i) begin
        mrdata_next = mgmt_port_i ? res_byte[1] : res_byte[0];
      end else begin
        mrdata_next = mgmt_port_i ? spec_byte[1] : spec_byte[0];
      end
    end
  end

  // Management read registers.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mrdata_reg <= 8'h00;
      mrvalid_reg <= 1'b0;
    end else begin
      mrdata_reg <= mrdata_next;
      mrvalid_reg <= mrvalid_next;
    end
  end

  assign mgmt_rdata_o = mrdata_reg;
  assign mgmt_rvalid_o = mrvalid_reg;

endmodule

// file: verification/pcd_special_ctrl_props.sv
`timescale 1ns/1ps
// Port timing checks, kept apart so the design itself stays free of checker logic.
module pcd_special_ctrl_props #(
  parameter int unsigned DIAG_TIMEOUT_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  input wire logic mgmt_rvalid_o,
  input wire logic [1:0] diag_start_o,
  input wire logic [1:0] diag_busy_o,
  input wire logic [1:0] diag_done_i,
  input wire logic [1:0] force_link_o,
  input wire logic [1:0] power_save_en_o,
  input wire logic [1:0] remote_loop_o
);
  localparam int TMO = DIAG_TIMEOUT_CYCLES + 2;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Read data must not move without a read, or software could see torn values.
  AST_RD_ANSWER: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("switch read not answered");
  AST_RD_QUIET: assert property (!reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o))
    else $error("switch read data moved without a read");
  AST_MGMT_ANSWER: assert property (mgmt_rd_i |=> mgmt_rvalid_o)
    else $error("management read not answered");
  AST_START_CAUSE: assert property (diag_start_o[0] |-> $past(reg_wr_i || mgmt_wr_i))
    else $error("test started without a write");
  AST_START_PULSE: assert property (diag_start_o[0] |=> !diag_start_o[0] && diag_busy_o[0])
    else $error("start not a single pulse into busy");
  AST_DONE_ENDS: assert property (diag_busy_o[0] && diag_done_i[0] |=> !diag_busy_o[0])
    else $error("busy did not end on done");
  AST_BUSY_BOUND: assert property ($rose(diag_busy_o[1]) |-> ##[1:TMO] !diag_busy_o[1])
    else $error("test ran past its time limit");
  AST_CTRL_WRITE: assert property (
    !$stable({force_link_o, power_save_en_o, remote_loop_o}) |-> $past(reg_wr_i || mgmt_wr_i))
    else $error("port control moved without a write");
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int unsigned TMO = 20;
  logic clk_i, resetn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, mgmt_port_i, mgmt_sel_result_i;
  logic mgmt_wr_i, mgmt_rd_i, mgmt_rvalid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, mgmt_wdata_i, mgmt_rdata_o, last1;
  logic [1:0] diag_start_o, diag_busy_o, diag_done_i, diag_near_short_i;
  logic [1:0] force_link_o, power_save_en_o, remote_loop_o;
  logic [3:0] diag_result_i;
  logic [17:0] diag_count_i;
  int err_count, checks_done;
  pcd_special_ctrl #(.DIAG_TIMEOUT_CYCLES(TMO)) pcd_special_ctrl_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .mgmt_port_i(mgmt_port_i),
    .mgmt_sel_result_i(mgmt_sel_result_i), .mgmt_wdata_i(mgmt_wdata_i),
    .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_rdata_o(mgmt_rdata_o),
    .mgmt_rvalid_o(mgmt_rvalid_o), .diag_start_o(diag_start_o), .diag_busy_o(diag_busy_o),
    .diag_done_i(diag_done_i), .diag_result_i(diag_result_i),
    .diag_near_short_i(diag_near_short_i), .diag_count_i(diag_count_i),
    .force_link_o(force_link_o), .power_save_en_o(power_save_en_o),
    .remote_loop_o(remote_loop_o));
  // Free-running 20 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Inputs always move 1 ns after the rising edge, so the design never races the bench.
  task automatic cyc;
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc();
    reg_wr_i = 1'b0;
    cyc();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc();
    reg_rd_i = 1'b0;
    chk({7'h00, reg_rvalid_o}, 8'h01);
    chk(reg_rdata_o, e);
    cyc();
  endtask
  task automatic mw(input logic p, input logic [7:0] d);
    mgmt_port_i = p;
    mgmt_sel_result_i = 1'b0;
    mgmt_wdata_i = d;
    mgmt_wr_i = 1'b1;
    cyc();
    mgmt_wr_i = 1'b0;
    cyc();
  endtask
  task automatic mrchk(input logic p, input logic s, input logic [7:0] e);
    mgmt_port_i = p;
    mgmt_sel_result_i = s;
    mgmt_rd_i = 1'b1;
    cyc();
    mgmt_rd_i = 1'b0;
    chk({7'h00, mgmt_rvalid_o}, 8'h01);
    chk(mgmt_rdata_o, e);
    cyc();
  endtask
  // A busy flag that never reaches the wanted level ends the run as a failure.
  task automatic wait_busy(input int p, input logic lvl);
    for (int i = 0; i < 40 && diag_busy_o[p] !== lvl; i++) cyc();
    if (diag_busy_o[p] !== lvl) begin
      err_count++;
      $display("MISMATCH t=%0t busy wait ran out", $time);
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(8'h1a, 8'h04);
    rchk(8'h1b, 8'h00);
    rchk(8'h2a, 8'h04);
    chk({2'b00, force_link_o, power_save_en_o, remote_loop_o}, 8'h00);
  endtask
  // Read-only bits written as ones must stay clear.
  task automatic t_ctrl;
    wr(8'h1a, 8'heb);
    chk({force_link_o[0], power_save_en_o[0], remote_loop_o[0]}, 8'h07);
    rchk(8'h1a, 8'h0a);
    wr(8'h1a, 8'h04);
    chk({force_link_o[0], power_save_en_o[0], remote_loop_o[0]}, 8'h00);
    mw(1'b1, 8'h08);
    chk({force_link_o[1], power_save_en_o[1], remote_loop_o[1]}, 8'h06);
    rchk(8'h2a, 8'h08);
    mrchk(1'b0, 1'b0, 8'h04);
  endtask
  task automatic t_rsvd;
    wr(8'h3a, 8'hff);
    rchk(8'h3a, 8'h00);
    wr(8'h1b, 8'hff);
    rchk(8'h1b, 8'h00);
  endtask
  task automatic t_diag(input logic [1:0] code, input logic [8:0] cnt);
    logic [7:0] e;
    e = {code == 2'h2, code, 4'h2, cnt[8]};
    diag_result_i[1:0] = code;
    diag_near_short_i[0] = code == 2'h2;
    diag_count_i[8:0] = cnt;
    wr(8'h1a, 8'h14);
    wait_busy(0, 1'b1);
    rchk(8'h1a, last1 | 8'h14);
    diag_done_i[0] = 1'b1;
    cyc();
    diag_done_i[0] = 1'b0;
    wait_busy(0, 1'b0);
    rchk(8'h1a, e);
    rchk(8'h1b, cnt[7:0]);
    mrchk(1'b0, 1'b1, cnt[7:0]);
    diag_result_i[1:0] = ~code;
    diag_done_i[0] = 1'b1;
    cyc();
    diag_done_i[0] = 1'b0;
    rchk(8'h1a, e);
    last1 = e & 8'he1;
  endtask
  // No done ever comes back on port 2, so the time limit must declare the test failed.
  // The start pulse stands only in the cycle after the write edge, so it is looked at there.
  task automatic t_tmo;
    reg_addr_i = 8'h2a;
    reg_wdata_i = 8'h18;
    reg_wr_i = 1'b1;
    cyc();
    reg_wr_i = 1'b0;
    chk({6'h00, diag_start_o}, 8'h02);
    cyc();
    chk({4'h0, diag_start_o, diag_busy_o}, 8'h02);
    wait_busy(1, 1'b1);
    wait_busy(1, 1'b0);
    rchk(8'h2a, 8'h68);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, mgmt_port_i, mgmt_sel_result_i, mgmt_wr_i} = '0;
    {mgmt_rd_i, reg_addr_i, reg_wdata_i, mgmt_wdata_i, last1} = '0;
    {diag_done_i, diag_near_short_i, diag_result_i, diag_count_i} = '0;
    err_count = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    t_ctrl();
    t_rsvd();
    for (int c = 0; c < 4; c++) t_diag(c[1:0], {c[0], 8'ha5 ^ c[7:0]});
    t_tmo();
    complete_run();
  end
endmodule

bind pcd_special_ctrl pcd_special_ctrl_props #(.DIAG_TIMEOUT_CYCLES(DIAG_TIMEOUT_CYCLES))
  pcd_special_ctrl_props_i (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_rvalid_o(mgmt_rvalid_o),
  .diag_start_o(diag_start_o), .diag_busy_o(diag_busy_o), .diag_done_i(diag_done_i),
  .force_link_o(force_link_o), .power_save_en_o(power_save_en_o),
  .remote_loop_o(remote_loop_o));
